// [common/mpsa_defs.svh]
// Timing, field and encoding constants for the page-store activate block
`ifndef MPSA_DEFS_SVH
`define MPSA_DEFS_SVH

// ======================================================================
// Clock and cycle conversion
// ======================================================================
`define MPSA_CLK_PS 8000
// Least times round up, longest times round down
`define MPSA_CEIL_CYC(ns) ((((ns) * 1000) + `MPSA_CLK_PS - 1) / `MPSA_CLK_PS)
`define MPSA_FLOOR_CYC(ns) (((ns) * 1000) / `MPSA_CLK_PS)

// ======================================================================
// Core timings in ns
// ======================================================================
`define MPSA_T_AA_MIN_NS 15
`define MPSA_T_AA_MAX_NS 18
`define MPSA_T_RCD_NS 135
`define MPSA_T_RAS_NS 143
`define MPSA_T_RC_NS 190
`define MPSA_T_ST_NS 380
`define MPSA_T_VREF_NS 150

// ======================================================================
// Mode register 6 layout and reset value
// ======================================================================
`define MPSA_MR6_SEL 4'h6
`define MPSA_MR6_TRAIN_BIT 7
`define MPSA_MR6_RANGE_BIT 6
`define MPSA_MR6_CODE_MSB 5
`define MPSA_MR6_RESET 8'h00

// ======================================================================
// Reference level, in units of 0.05 percent of the I/O supply
// ======================================================================
`define MPSA_VREF_R1_BASE 11'h4b0
`define MPSA_VREF_R2_BASE 11'h384
`define MPSA_VREF_STEP 11'h00d
`define MPSA_CODE_LAST 6'h3f

// ======================================================================
// Measurement-loop rows
// ======================================================================
`define MPSA_LOOP_ROW_A 16'h0000
`define MPSA_LOOP_ROW_B 16'h03f8

`endif

// [common/mpsa_pkg.sv]
// Types shared by both ends of the page-store activate block
package mpsa_pkg;
    // Command on the command bus
    typedef enum logic [2:0] {
        MPSA_DES, MPSA_ACT, MPSA_WR, MPSA_RD, MPSA_PRE, MPSA_MRS
    } mpsa_cmd_t;
    // Device store sequencer
    typedef enum logic {MPSA_DEV_RUN, MPSA_DEV_STORE} mpsa_dev_st_t;
    // Controller sequencer
    typedef enum logic [1:0] {
        MPSA_C_IDLE, MPSA_C_LOOP, MPSA_C_CAL, MPSA_C_SETTLE
    } mpsa_ctl_st_t;
endpackage : mpsa_pkg

// [common/mpsa_if.sv]
// Command interface between controller and page-store device
`timescale 1ns/10ps
interface mpsa_if import mpsa_pkg::*; #(
    parameter int BANK_W = 4,
    parameter int ROW_W = 16,
    parameter int DATA_W = 8
)(
    input wire logic clk,
    input wire logic rst
);
    mpsa_cmd_t cmd;              // Command, one cycle each
    logic [BANK_W-1:0] bank;     // Bank, or mode register select
    logic [ROW_W-1:0] addr;      // Row, or mode register value
    logic [DATA_W-1:0] wdata;    // Write data with WR
    logic [DATA_W-1:0] rdata;    // Read data
    logic rd_valid;              // Read data valid
    logic busy;                  // Store in progress

    modport ctrl_mp (input clk, input rst, output cmd, output bank,
        output addr, output wdata, input rdata, input rd_valid, input busy);
    modport dev_mp (input clk, input rst, input cmd, input bank,
        input addr, input wdata, output rdata, output rd_valid, output busy);
endinterface : mpsa_if

// [design/mpsa_device.sv]
// Page-store device end: reference setting, page buffers, store, reads
`timescale 1ns/10ps
`include "mpsa_defs.svh"
// ======================================================================
// Summary of operation
// RL1: Mode register bit 6 selects reference range
// RL2: Six-bit code selects reference level
// RL3: Range and level apply regardless of bit 7
// RL4: New reference level settles within 150 ns
// RL5: Each code step moves reference one step
// RL6: Controller calibrates the reference level
// RL7: First read data 15 to 18 ns
// RL8: Controller waits 135 ns activate to access
// RL9: Controller waits 143 ns activate to precharge
// RL10: Controller waits 190 ns between activates
// RL11: Different row same bank stores, 380 ns
// RL12: Activate to other bank does no store
// RL13: Page buffer kept until power loss or store
// RL14: Same row re-activate never stores
// RL15: Measurement loop alternates rows 0x0000, 0x03F8
// RL16: Loop: activate, write, precharge, next activate
// RL17: Device records open flag and row per bank
// ======================================================================
module mpsa_device import mpsa_pkg::*; #(
    parameter int NB = 16,
    parameter int BANK_W = 4,
    parameter int ROW_W = 16,
    parameter int DATA_W = 8,
    parameter int IDX_W = 4
)(
    mpsa_if.dev_mp bus,
    output logic vref_range,
    output logic [5:0] vref_code,
    output logic [10:0] vref_level,
    output logic vref_settled,
    output logic [15:0] store_count
);
    // ==================================================================
    // Derived cycle counts
    // ==================================================================
    localparam int AA_CYC = `MPSA_CEIL_CYC(`MPSA_T_AA_MIN_NS);
    localparam int ST_CYC = `MPSA_CEIL_CYC(`MPSA_T_ST_NS);
    localparam int VREF_CYC = `MPSA_FLOOR_CYC(`MPSA_T_VREF_NS);
    localparam int CNT_W = $clog2(ST_CYC + 1);
    localparam int VCNT_W = $clog2(VREF_CYC + 1);
    localparam int PM_N = NB * (2 ** IDX_W);
    localparam int PM_W = BANK_W + IDX_W;

    // Persistent array slot of a bank and row
    function automatic logic [PM_W-1:0] pidx(
        input logic [BANK_W-1:0] b,
        input logic [ROW_W-1:0] r
    );
        pidx = {b, r[IDX_W-1:0]};
    endfunction : pidx

    // Reference level from range and code, 0.05 percent units
    function automatic logic [10:0] vlevel(
        input logic rng,
        input logic [5:0] code
    );
        logic [10:0] base;
        base = rng ? `MPSA_VREF_R2_BASE : `MPSA_VREF_R1_BASE;
        vlevel = base + 11'(code * `MPSA_VREF_STEP);
    endfunction : vlevel

    // ==================================================================
    // State
    // ==================================================================
    mpsa_dev_st_t state_r;              // Store sequencer
    logic [CNT_W-1:0] cnt_r;            // Store cycles left
    logic [NB-1:0] open_r;              // Bank buffer holds a row
    logic [ROW_W-1:0] row_r [NB];       // Row held per bank
    logic [DATA_W-1:0] page_r [NB];     // Volatile page buffers
    logic [DATA_W-1:0] pmem_r [PM_N];   // Persistent array
    logic [BANK_W-1:0] pend_bank_r;     // Bank waiting on store
    logic [ROW_W-1:0] pend_row_r;       // Row to open after store
    logic [7:0] mr6_r;                  // Mode register 6
    logic [10:0] level_r;               // Reference level
    logic [VCNT_W-1:0] vcnt_r;          // Settle countdown
    logic settled_r;                    // Reference has settled
    logic [AA_CYC-1:0] rdv_r;           // Read valid pipeline
    logic [DATA_W-1:0] rdd_r [AA_CYC];  // Read data pipeline
    logic [15:0] stores_r;              // Stores performed
    logic busy_r;                       // Store in progress

    // ==================================================================
    // Command decode
    // ==================================================================
    wire run = (state_r == MPSA_DEV_RUN);
    // Commands during a store are ignored; the controller waits on busy
    wire take_act = run && (bus.cmd == MPSA_ACT);
    wire take_wr = run && (bus.cmd == MPSA_WR);
    wire take_rd = run && (bus.cmd == MPSA_RD);
    wire take_mr6 = run && (bus.cmd == MPSA_MRS)
        && (bus.bank == `MPSA_MR6_SEL);
    // Store only for a different row of an already opened bank
    wire row_differs = (row_r[bus.bank] != bus.addr);
    wire need_store = take_act && open_r[bus.bank] && row_differs; // RL11
    // First open of a bank loads its page; same row keeps it
    wire first_open = take_act && !open_r[bus.bank]; // RL14
    wire store_done = !run && (cnt_r == '0);
    wire [PM_W-1:0] old_slot = pidx(bus.bank, row_r[bus.bank]);
    wire [PM_W-1:0] new_slot = pidx(bus.bank, bus.addr);
    wire [PM_W-1:0] pend_slot = pidx(pend_bank_r, pend_row_r);
    wire mr6_rng = bus.addr[`MPSA_MR6_RANGE_BIT];
    wire [5:0] mr6_code = bus.addr[`MPSA_MR6_CODE_MSB:0];

    // ==================================================================
    // Store sequencer
    // ==================================================================
    // Counts the store period before the new row is opened
    always_ff @(posedge bus.clk or posedge bus.rst) begin
        if (bus.rst) begin
            state_r <= MPSA_DEV_RUN;
            cnt_r <= '0;
            busy_r <= 1'b0;
            stores_r <= 16'h0000;
        end else if (need_store) begin
            state_r <= MPSA_DEV_STORE; // RL11
            cnt_r <= CNT_W'(ST_CYC - 1); // RL11
            busy_r <= 1'b1;
            stores_r <= stores_r + 16'h0001;
        end else if (store_done) begin
            state_r <= MPSA_DEV_RUN;
            busy_r <= 1'b0;
        end else if (!run) begin
            cnt_r <= cnt_r - CNT_W'(1);
        end
    end

    // Pending activate held across the store
    always_ff @(posedge bus.clk or posedge bus.rst) begin
        if (bus.rst) begin
            pend_bank_r <= '0;
            pend_row_r <= '0;
        end else if (need_store) begin
            pend_bank_r <= bus.bank;
            pend_row_r <= bus.addr;
        end
    end

    // ==================================================================
    // Per-bank page buffers and open-row record
    // ==================================================================
    // Reset stands for power-up: buffers start empty and closed
    always_ff @(posedge bus.clk or posedge bus.rst) begin
        if (bus.rst) begin
            for (int i = 0; i < NB; i++) begin
                open_r[i] <= 1'b0;
                row_r[i] <= '0;
                page_r[i] <= '0;
            end
        end else begin
            // Other banks untouched by an activate here
            if (first_open) begin // RL12
                open_r[bus.bank] <= 1'b1; // RL17
                row_r[bus.bank] <= bus.addr; // RL17
                page_r[bus.bank] <= pmem_r[new_slot];
            end
            // After the store the new row enters the buffer
            if (store_done) begin
                row_r[pend_bank_r] <= pend_row_r; // RL17
                page_r[pend_bank_r] <= pmem_r[pend_slot]; // RL11
            end
            // Writes land in the volatile buffer only
            if (take_wr) begin
                page_r[bus.bank] <= bus.wdata; // RL13
            end
        end
    end

    // Persistent array; written only by a store
    always_ff @(posedge bus.clk or posedge bus.rst) begin
        if (bus.rst) begin
            for (int i = 0; i < PM_N; i++) begin
                pmem_r[i] <= '0;
            end
        end else if (need_store) begin
            pmem_r[old_slot] <= page_r[bus.bank]; // RL11
        end
    end

    // ==================================================================
    // Mode register 6 and internal reference
    // ==================================================================
    // Range and code take effect whatever the training bit says
    always_ff @(posedge bus.clk or posedge bus.rst) begin
        if (bus.rst) begin
            mr6_r <= `MPSA_MR6_RESET;
            level_r <= `MPSA_VREF_R1_BASE;
        end else if (take_mr6) begin
            mr6_r <= bus.addr[`MPSA_MR6_TRAIN_BIT:0]; // RL3
            level_r <= vlevel(mr6_rng, mr6_code); // RL1 RL2 RL5
        end
    end

    // Settle window after any level change
    always_ff @(posedge bus.clk or posedge bus.rst) begin
        if (bus.rst) begin
            vcnt_r <= '0;
            settled_r <= 1'b1;
        end else if (take_mr6 && (vlevel(mr6_rng, mr6_code) != level_r)) begin
            vcnt_r <= VCNT_W'(VREF_CYC - 1); // RL4
            settled_r <= 1'b0;
        end else if (vcnt_r != '0) begin
            vcnt_r <= vcnt_r - VCNT_W'(1);
        end else begin
            settled_r <= 1'b1; // RL4
        end
    end

    // ==================================================================
    // Read latency pipeline
    // ==================================================================
    // Fixed latency at the least access time keeps data inside the window
    always_ff @(posedge bus.clk or posedge bus.rst) begin
        if (bus.rst) begin
            rdv_r <= '0;
            for (int i = 0; i < AA_CYC; i++) begin
                rdd_r[i] <= '0;
            end
        end else begin
            rdv_r <= {rdv_r[AA_CYC-2:0], take_rd}; // RL7
            rdd_r[0] <= page_r[bus.bank];
            for (int i = 1; i < AA_CYC; i++) begin
                rdd_r[i] <= rdd_r[i-1]; // RL7
            end
        end
    end

    // ==================================================================
    // Outputs, all from flip-flops
    // ==================================================================
    assign bus.rd_valid = rdv_r[AA_CYC-1];
    assign bus.rdata = rdd_r[AA_CYC-1];
    assign bus.busy = busy_r;
    assign vref_range = mr6_r[`MPSA_MR6_RANGE_BIT];
    assign vref_code = mr6_r[`MPSA_MR6_CODE_MSB:0];
    assign vref_level = level_r;
    assign vref_settled = settled_r;
    assign store_count = stores_r;
endmodule : mpsa_device

// [design/mpsa_ctrl.sv]
// Controller end: reference calibration and store-forcing measurement loop
`timescale 1ns/10ps
`include "mpsa_defs.svh"
module mpsa_ctrl import mpsa_pkg::*; #(
    parameter int BANK_W = 4,
    parameter int ROW_W = 16,
    parameter int DATA_W = 8
)(
    mpsa_if.ctrl_mp bus,
    input wire logic run,
    input wire logic cal_start,
    input wire logic cal_range,
    input wire logic cal_pass,
    output logic cal_done,
    output logic [5:0] cal_code,
    output logic loop_active,
    output logic [15:0] act_count
);
    // ==================================================================
    // Derived cycle counts, all rounded up as least times
    // ==================================================================
    localparam int RCD_CYC = `MPSA_CEIL_CYC(`MPSA_T_RCD_NS);
    localparam int RAS_CYC = `MPSA_CEIL_CYC(`MPSA_T_RAS_NS);
    localparam int RC_CYC = `MPSA_CEIL_CYC(`MPSA_T_RC_NS);
    // One extra cycle covers the registered command
    localparam int VW_CYC = `MPSA_CEIL_CYC(`MPSA_T_VREF_NS) + 1;
    localparam int CW = 6;

    // Bank visiting order of the measurement loop
    function automatic logic [3:0] bank_seq(input logic [3:0] i);
        logic [3:0] t [16];
        t = '{4'h0, 4'h5, 4'h2, 4'h7, 4'h1, 4'h6, 4'h3, 4'h4,
              4'h8, 4'hd, 4'ha, 4'hf, 4'h9, 4'he, 4'hb, 4'hc};
        bank_seq = t[i];
    endfunction : bank_seq

    // ==================================================================
    // State
    // ==================================================================
    mpsa_ctl_st_t st_r;              // Sequencer
    logic [CW-1:0] cyc_r;            // Cycle within one activate period
    logic [3:0] bidx_r;              // Position in bank order
    logic alt_r;                     // Second row of the pair
    mpsa_cmd_t cmd_r;                // Registered command
    logic [BANK_W-1:0] bank_r;
    logic [ROW_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    logic [5:0] code_r;              // Code under trial
    logic [5:0] first_r;             // First passing code
    logic [5:0] last_r;              // Last passing code
    logic found_r;
    logic done_r;
    logic [15:0] acts_r;

    wire [3:0] cur_bank = bank_seq(bidx_r);
    wire [ROW_W-1:0] cur_row = alt_r ? `MPSA_LOOP_ROW_B : `MPSA_LOOP_ROW_A;
    wire wait_done = (cyc_r == CW'(VW_CYC - 1));
    wire [6:0] pass_sum = {1'b0, first_r} + {1'b0, last_r};
    wire [5:0] center = pass_sum[6:1];

    // ==================================================================
    // Sequencer
    // ==================================================================
    // Holds the period counter while the device is storing
    always_ff @(posedge bus.clk or posedge bus.rst) begin
        if (bus.rst) begin
            st_r <= MPSA_C_IDLE;
            cyc_r <= '0;
            bidx_r <= 4'h0;
            alt_r <= 1'b0;
            cmd_r <= MPSA_DES;
            bank_r <= '0;
            addr_r <= '0;
            wdata_r <= '0;
            code_r <= 6'h00;
            first_r <= 6'h00;
            last_r <= 6'h00;
            found_r <= 1'b0;
            done_r <= 1'b0;
            acts_r <= 16'h0000;
        end else begin
            cmd_r <= MPSA_DES;
            unique case (st_r)
                MPSA_C_IDLE: begin
                    cyc_r <= '0;
                    if (cal_start) begin
                        // Sweep from the lowest code, training bit set
                        st_r <= MPSA_C_CAL; // RL6
                        code_r <= 6'h00;
                        found_r <= 1'b0;
                        done_r <= 1'b0;
                        cmd_r <= MPSA_MRS;
                        bank_r <= BANK_W'(`MPSA_MR6_SEL);
                        addr_r <= ROW_W'({1'b1, cal_range, 6'h00});
                    end else if (run) begin
                        st_r <= MPSA_C_LOOP;
                    end
                end
                MPSA_C_LOOP: begin
                    if (cyc_r == '0) begin
                        cmd_r <= MPSA_ACT; // RL16
                        bank_r <= BANK_W'(cur_bank);
                        addr_r <= cur_row; // RL15
                        acts_r <= acts_r + 16'h0001;
                        cyc_r <= CW'(1);
                    end else if (!bus.busy) begin
                        cyc_r <= cyc_r + CW'(1);
                        if (cyc_r == CW'(RCD_CYC)) begin
                            cmd_r <= MPSA_WR; // RL8 RL16
                            wdata_r <= acts_r[DATA_W-1:0];
                        end
                        if (cyc_r == CW'(RAS_CYC)) begin
                            cmd_r <= MPSA_PRE; // RL9 RL16
                        end
                        if (cyc_r == CW'(RC_CYC - 1)) begin
                            cyc_r <= '0; // RL10
                            alt_r <= !alt_r; // RL15
                            if (alt_r) begin
                                bidx_r <= bidx_r + 4'h1; // RL16
                            end
                            if (!run) begin
                                st_r <= MPSA_C_IDLE;
                            end
                        end
                    end
                end
                MPSA_C_CAL: begin
                    cyc_r <= cyc_r + CW'(1);
                    if (wait_done) begin
                        // Sample only after the level has settled
                        cyc_r <= '0; // RL4
                        if (cal_pass) begin
                            last_r <= code_r;
                            if (!found_r) begin
                                first_r <= code_r;
                            end
                            found_r <= 1'b1;
                        end
                        cmd_r <= MPSA_MRS;
                        if (code_r == `MPSA_CODE_LAST) begin
                            st_r <= MPSA_C_SETTLE;
                            addr_r <= ROW_W'({1'b0, cal_range, center});
                        end else begin
                            code_r <= code_r + 6'h01; // RL6
                            addr_r <= ROW_W'({1'b1, cal_range,
                                code_r + 6'h01});
                        end
                    end
                end
                MPSA_C_SETTLE: begin
                    cyc_r <= cyc_r + CW'(1);
                    if (wait_done) begin
                        cyc_r <= '0; // RL4
                        code_r <= addr_r[5:0];
                        done_r <= 1'b1;
                        st_r <= MPSA_C_IDLE;
                    end
                end
            endcase
        end
    end

    // ==================================================================
    // Outputs from flip-flops, except loop_active, which is decoded from st_r
    // ==================================================================
    assign bus.cmd = cmd_r;
    assign bus.bank = bank_r;
    assign bus.addr = addr_r;
    assign bus.wdata = wdata_r;
    assign cal_done = done_r;
    assign cal_code = code_r;
    assign loop_active = (st_r == MPSA_C_LOOP) ? 1'b1 : 1'b0;
    assign act_count = acts_r;
endmodule : mpsa_ctrl

// [testbench/mpsa_monitor.sv]
// Command-bus checker between controller and page-store device
`timescale 1ns/10ps
module mpsa_monitor import mpsa_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input mpsa_cmd_t cmd,
    input wire logic [3:0] bank,
    input wire logic [15:0] addr,
    input wire logic busy
);
    // ==================================================================
    // Helper state
    // ==================================================================
    logic [7:0] gap_r;   // Free cycles since last taken ACT
    logic [7:0] blen_r;  // Length of the running store
    logic [3:0] lbank_r; // Bank of last taken ACT
    logic [15:0] lrow_r; // Row of last taken ACT
    wire act_ok = (cmd == MPSA_ACT) && !busy; // ACT the device takes
    // Gap freezes while busy, matching the controller's own count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_r <= 8'hff;
            blen_r <= 8'h00;
            lbank_r <= 4'h0;
            lrow_r <= 16'hffff; // Not a loop row, so no false hit
        end else begin
            blen_r <= busy ? blen_r + 8'h01 : 8'h00;
            if (act_ok) begin
                gap_r <= 8'h01;
                lbank_r <= bank;
                lrow_r <= addr;
            end else if (!busy && gap_r != 8'hff) begin
                gap_r <= gap_r + 8'h01;
            end
        end
    end
    // ==================================================================
    // Assertions
    // ==================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_store_length: assert property ($fell(busy) |-> blen_r == 8'h30)
        else $error("store length wrong");
    a_store_cause: assert property ($rose(busy) |-> $past(cmd) == MPSA_ACT)
        else $error("store without activate");
    a_quiet_busy: assert property (busy |-> cmd == MPSA_DES)
        else $error("command during store");
    a_act_to_wr: assert property (cmd == MPSA_WR && !busy |-> gap_r >= 8'h11)
        else $error("write too soon");
    a_act_to_pre: assert property (cmd == MPSA_PRE && !busy |-> gap_r >= 8'h12)
        else $error("precharge too soon");
    a_act_to_act: assert property (act_ok |-> gap_r >= 8'h18)
        else $error("activate too soon");
    a_loop_rows: assert property (cmd == MPSA_ACT |->
        addr == 16'h0000 || addr == 16'h03f8)
        else $error("loop row wrong");
    a_row_alternate: assert property (act_ok && bank == lbank_r |->
        addr != lrow_r)
        else $error("row repeated");
    a_pair_bank: assert property (act_ok && addr == 16'h03f8 |->
        bank == lbank_r)
        else $error("pair split across banks");
    a_mrs_select: assert property (cmd == MPSA_MRS |-> bank == 4'h6)
        else $error("mode write off target");
endmodule : mpsa_monitor

// [testbench/tb_mram_page_store_activate.sv]
// Testbench joining controller and device ends
`timescale 1ns/10ps
module tb_mram_page_store_activate import mpsa_pkg::*; ;
    logic clk = 1'b0, rst = 1'b1, run = 1'b0, cal_start = 1'b0;
    logic cal_range = 1'b0, cal_pass = 1'b0, dipped = 1'b0;
    logic cal_done, loop_active, vref_range, vref_settled;
    logic [5:0] cal_code, vref_code, lo = 6'h00, hi = 6'h00;
    logic [10:0] vref_level;
    logic [15:0] act_count, store_count;
    int failures = 0, checks = 0;
    always #4 clk = ~clk;
    // ==================================================================
    // Both ends and the checker
    // ==================================================================
    mpsa_if i_mpsa_if (.clk(clk), .rst(rst));
    mpsa_ctrl i_mpsa_ctrl (.bus(i_mpsa_if.ctrl_mp), .run(run),
        .cal_start(cal_start), .cal_range(cal_range), .cal_pass(cal_pass),
        .cal_done(cal_done), .cal_code(cal_code),
        .loop_active(loop_active), .act_count(act_count));
    mpsa_device i_mpsa_device (.bus(i_mpsa_if.dev_mp),
        .vref_range(vref_range), .vref_code(vref_code),
        .vref_level(vref_level), .vref_settled(vref_settled),
        .store_count(store_count));
    mpsa_monitor i_mpsa_monitor (.clk(clk), .rst(rst), .cmd(i_mpsa_if.cmd),
        .bank(i_mpsa_if.bank), .addr(i_mpsa_if.addr),
        .busy(i_mpsa_if.busy));
    // Receiver eye: passes only inside the lo..hi code window
    always @(posedge clk) begin
        cal_pass <= (vref_code >= lo) && (vref_code <= hi);
        if (vref_settled === 1'b0) dipped <= 1'b1;
    end
    // ==================================================================
    // Tasks
    // ==================================================================
    task chk(input string what, input logic [15:0] got,
             input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task results;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    // Timeout counts as a mismatch and closes the run
    task limit(input int n);
        if (n >= 6000) begin
            chk("wait", 16'h0001, 16'h0000);
            results();
        end
    endtask : limit
    // Full reference sweep with a pass window, then the chosen setting
    task calib(input logic rng, input logic [5:0] l, input logic [5:0] h,
               input logic [5:0] mid, input logic [10:0] lvl);
        int n;
        lo = l;
        hi = h;
        dipped = 1'b0;
        @(posedge clk);
        cal_range <= rng;
        cal_start <= 1'b1;
        @(posedge clk);
        cal_start <= 1'b0;
        @(negedge clk);
        for (n = 0; n < 6000 && cal_done !== 1'b1; n++) @(negedge clk);
        limit(n);
        chk("cal_code", {10'h000, cal_code}, {10'h000, mid});
        chk("vref_code", {10'h000, vref_code}, {10'h000, mid});
        chk("vref_range", {15'h0000, vref_range}, {15'h0000, rng});
        chk("vref_level", {5'h00, vref_level}, {5'h00, lvl});
        chk("dipped", {15'h0000, dipped}, 16'h0001);
        chk("settled", {15'h0000, vref_settled}, 16'h0001);
    endtask : calib
    // Wait for a number of activates issued by the loop
    task acts(input logic [15:0] cnt);
        int n;
        for (n = 0; n < 6000 && act_count !== cnt; n++) @(negedge clk);
        limit(n);
    endtask : acts
    // ==================================================================
    // Main sequence
    // ==================================================================
    initial begin
        int n;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("level_rst", {5'h00, vref_level}, 16'h04b0);
        chk("stores_rst", store_count, 16'h0000);
        calib(1'b1, 6'h0a, 6'h14, 6'h0f, 11'h447);
        calib(1'b0, 6'h28, 6'h32, 6'h2d, 11'h6f9);
        @(posedge clk);
        run <= 1'b1;
        acts(16'h0005);
        chk("stores_b5", store_count, 16'h0002);
        acts(16'h0022);
        @(posedge clk);
        run <= 1'b0;
        @(negedge clk);
        for (n = 0; n < 6000 && loop_active !== 1'b0; n++) @(negedge clk);
        limit(n);
        repeat (60) @(negedge clk);
        chk("acts", act_count, 16'h0022);
        chk("stores", store_count, 16'h0012);
        chk("busy", {15'h0000, i_mpsa_if.busy}, 16'h0000);
        results();
    end
endmodule : tb_mram_page_store_activate
